// ### verilog/irt_pkg.sv
// irt_pkg: register map, field layout, reset values and trim weights of the interrupt routing and offset trim bank
`default_nettype none
package irt_pkg;
	localparam logic [7:0] ADDR_ROUTING = 8'h2a; // interrupt_pin_routing
	localparam logic [7:0] ADDR_ENABLE = 8'h29; // per-source interrupt enable
	localparam logic [7:0] ADDR_P_TRIM = 8'h2b; // pressure_offset_trim
	localparam logic [7:0] ADDR_T_TRIM = 8'h2c; // temperature_offset_trim
	localparam logic [7:0] ADDR_H_TRIM = 8'h2d; // altitude_offset_trim
	localparam logic [7:0] RESET_ROUTING = 8'h00;
	localparam logic [7:0] RESET_ENABLE = 8'h00;
	localparam logic [7:0] RESET_TRIM = 8'h00;
	// source bit positions, shared by enable, routing and event vectors
	localparam int BIT_DATA_READY = 7;
	localparam int BIT_FIFO = 6;
	localparam int BIT_P_WINDOW = 5;
	localparam int BIT_T_WINDOW = 4;
	localparam int BIT_P_THRESH = 3;
	localparam int BIT_T_THRESH = 2;
	localparam int BIT_P_CHANGE = 1;
	localparam int BIT_T_CHANGE = 0;
	localparam int NUM_SRC = 8;
	// routing bit value that steers a source to the first pin
	localparam logic ROUTE_FIRST = 1'b1;
	// trim weights expressed as left shifts of the trim into the result lsb grid
	localparam int RES_W = 24; // width of compensated results
	localparam int P_FRAC_BITS = 2; // pressure result: 1/4 Pa per lsb, trim is 4 Pa/lsb
	localparam int P_TRIM_SHIFT = 4; // 4 Pa = 16 quarter pascals
	localparam int T_TRIM_SHIFT = 0; // temperature result in 1/16 degC, trim 1/16 degC/lsb
	localparam int H_FRAC_BITS = 4; // altitude result: 1/16 m per lsb, trim whole meters
	localparam int H_TRIM_SHIFT = 4;
endpackage : irt_pkg
`default_nettype wire

// ### verilog/irt_route.sv
// irt_route: gates enabled sources and ORs them onto the two interrupt pins
`timescale 1ns/100ps
`default_nettype none
module irt_route (
	input wire logic [7:0] src_event_i, // active event flags
	input wire logic [7:0] enable_i, // per-source enables
	input wire logic [7:0] routing_i, // 1 first pin, 0 second pin
	output logic pin_first_o, // combinational request for first pin
	output logic pin_second_o // combinational request for second pin
);
	logic [7:0] gated; // enabled events only
	logic [7:0] to_first; // events steered to the first pin
	logic [7:0] to_second; // events steered to the second pin

	// a disabled source never reaches either pin
	always_comb begin
		gated = src_event_i & enable_i; // R11
		to_first = gated & routing_i; // R1
		to_second = gated & ~routing_i; // R1
		pin_first_o = |to_first; // R4
		pin_second_o = |to_second; // R4
	end
endmodule // irt_route
`default_nettype wire

// ### verilog/irt_trim.sv
// irt_trim: applies a signed, scaled offset trim to one compensated result
`timescale 1ns/100ps
`default_nettype none
module irt_trim #(
	parameter int SHIFT = 0 // weight of one trim lsb in result lsbs, as a power of two
) (
	input wire logic signed [23:0] result_i, // compensated result before trim
	input wire logic [7:0] trim_i, // two's-complement trim
	output logic signed [23:0] result_o // trimmed result
);
	logic signed [23:0] scaled; // sign-extended trim in result units

	// sign extension first, then the weight; zero trim gives a zero addend
	always_comb begin
		scaled = 24'(signed'(trim_i)) <<< SHIFT; // R6
		result_o = 24'(result_i + scaled); // R12
	end
endmodule // irt_trim
`default_nettype wire

// ### verilog/irt_bank.sv
// irt_bank: interrupt routing and offset trim register bank with pin drive and result correction
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: routing bit 1 first pin, 0 second
// R2: routing register at 2Ah, one bit per source
// R3: routing bits reset to zero
// R4: each pin is OR of its routed sources
// R5: host reads source register to find cause
// R6: offsets are two's-complement result corrections
// R7: pressure trim weighs 4 Pa per lsb
// R8: temperature trim weighs 1/16 degC per lsb
// R9: altitude trim weighs one meter per lsb
// R10: trims at 2Bh, 2Ch, 2Dh, reset zero
// R11: disabled source never asserts any pin
// R12: trim added signed after scaling
module irt_bank (
	input wire logic core_clk_i, // 20 MHz core clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic reg_wr_i, // register write strobe from the serial slave
	input wire logic reg_rd_i, // register read strobe from the serial slave
	input wire logic [7:0] reg_addr_i, // register address
	input wire logic [7:0] reg_wdata_i, // write data
	output logic [7:0] reg_rdata_o, // registered read data
	input wire logic [7:0] src_event_i, // event flags from the detectors
	input wire logic signed [23:0] p_result_i, // pressure, quarter pascals
	input wire logic signed [23:0] t_result_i, // temperature, 1/16 degC
	input wire logic signed [23:0] h_result_i, // altitude, 1/16 m
	input wire logic result_valid_i, // one-cycle pulse, new results present
	output logic irq_pin_first_o, // first interrupt pin, active high
	output logic irq_pin_second_o, // second interrupt pin, active high
	output logic signed [23:0] p_out_o, // trimmed pressure
	output logic signed [23:0] t_out_o, // trimmed temperature
	output logic signed [23:0] h_out_o, // trimmed altitude
	output logic out_valid_o // one-cycle pulse, trimmed results updated
);
	// register state
	logic [7:0] routing_r, routing_nxt; // interrupt_pin_routing
	logic [7:0] enable_r, enable_nxt; // per-source enable
	logic [7:0] p_trim_r, p_trim_nxt; // pressure_offset_trim
	logic [7:0] t_trim_r, t_trim_nxt; // temperature_offset_trim
	logic [7:0] h_trim_r, h_trim_nxt; // altitude_offset_trim
	logic [7:0] rdata_r, rdata_nxt; // read data holding register
	// pin and result state
	logic pin_first_r, pin_first_nxt; // registered first pin
	logic pin_second_r, pin_second_nxt; // registered second pin
	logic signed [23:0] p_out_r, p_out_nxt; // trimmed pressure
	logic signed [23:0] t_out_r, t_out_nxt; // trimmed temperature
	logic signed [23:0] h_out_r, h_out_nxt; // trimmed altitude
	logic valid_r, valid_nxt; // result update pulse
	// combinational results from the leaves
	logic route_first; // first pin request
	logic route_second; // second pin request
	logic signed [23:0] p_trimmed; // pressure after trim
	logic signed [23:0] t_trimmed; // temperature after trim
	logic signed [23:0] h_trimmed; // altitude after trim
	// named views of the routing fields; 1 sends the source to the first pin
	logic route_sel_data_ready; // data ready routing
	logic route_sel_fifo; // fifo routing
	logic route_sel_pressure_window; // pressure window routing
	logic route_sel_temperature_window; // temperature window routing
	logic route_sel_pressure_threshold; // pressure threshold routing
	logic route_sel_temperature_threshold; // temperature threshold routing
	logic route_sel_pressure_change; // pressure change routing
	logic route_sel_temperature_change; // temperature change routing
	logic [7:0] route_view; // fields packed back at their package positions

	// write decoding for each 8-bit register
	always_comb begin
		routing_nxt = routing_r;
		enable_nxt = enable_r;
		p_trim_nxt = p_trim_r;
		t_trim_nxt = t_trim_r;
		h_trim_nxt = h_trim_r;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				irt_pkg::ADDR_ROUTING: routing_nxt = reg_wdata_i; // R2
				irt_pkg::ADDR_ENABLE: enable_nxt = reg_wdata_i; // R11
				irt_pkg::ADDR_P_TRIM: p_trim_nxt = reg_wdata_i; // R10
				irt_pkg::ADDR_T_TRIM: t_trim_nxt = reg_wdata_i; // R10
				irt_pkg::ADDR_H_TRIM: h_trim_nxt = reg_wdata_i; // R10
				default: begin
					// other addresses belong to other banks; ignored here
				end
			endcase
		end
	end

	// read mux; unmapped addresses read zero and keep the last value otherwise
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				irt_pkg::ADDR_ROUTING: rdata_nxt = routing_r; // R2
				irt_pkg::ADDR_ENABLE: rdata_nxt = enable_r;
				irt_pkg::ADDR_P_TRIM: rdata_nxt = p_trim_r; // R10
				irt_pkg::ADDR_T_TRIM: rdata_nxt = t_trim_r; // R10
				irt_pkg::ADDR_H_TRIM: rdata_nxt = h_trim_r; // R10
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// register bank flops; all zero after reset so every source is disabled and steered to the second pin
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			routing_r <= irt_pkg::RESET_ROUTING; // R3
			enable_r <= irt_pkg::RESET_ENABLE;
			p_trim_r <= irt_pkg::RESET_TRIM; // R10
			t_trim_r <= irt_pkg::RESET_TRIM; // R10
			h_trim_r <= irt_pkg::RESET_TRIM; // R10
			rdata_r <= 8'h00;
		end else begin
			routing_r <= routing_nxt;
			enable_r <= enable_nxt;
			p_trim_r <= p_trim_nxt;
			t_trim_r <= t_trim_nxt;
			h_trim_r <= h_trim_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// field views of the routing register; positions come from the package so a
	// field move is one package edit and the pin logic never changes
	always_comb begin
		route_sel_data_ready = routing_r[irt_pkg::BIT_DATA_READY]; // R2
		route_sel_fifo = routing_r[irt_pkg::BIT_FIFO]; // R2
		route_sel_pressure_window = routing_r[irt_pkg::BIT_P_WINDOW]; // R2
		route_sel_temperature_window = routing_r[irt_pkg::BIT_T_WINDOW]; // R2
		route_sel_pressure_threshold = routing_r[irt_pkg::BIT_P_THRESH]; // R2
		route_sel_temperature_threshold = routing_r[irt_pkg::BIT_T_THRESH]; // R2
		route_sel_pressure_change = routing_r[irt_pkg::BIT_P_CHANGE]; // R2
		route_sel_temperature_change = routing_r[irt_pkg::BIT_T_CHANGE]; // R2
		// repack in event order so bit n of the view steers event bit n
		route_view = 8'h00;
		route_view[irt_pkg::BIT_DATA_READY] = route_sel_data_ready; // R1
		route_view[irt_pkg::BIT_FIFO] = route_sel_fifo; // R1
		route_view[irt_pkg::BIT_P_WINDOW] = route_sel_pressure_window; // R1
		route_view[irt_pkg::BIT_T_WINDOW] = route_sel_temperature_window; // R1
		route_view[irt_pkg::BIT_P_THRESH] = route_sel_pressure_threshold; // R1
		route_view[irt_pkg::BIT_T_THRESH] = route_sel_temperature_threshold; // R1
		route_view[irt_pkg::BIT_P_CHANGE] = route_sel_pressure_change; // R1
		route_view[irt_pkg::BIT_T_CHANGE] = route_sel_temperature_change; // R1
	end

	// gating and OR onto the pins; several sources may share a pin, so the host
	// must read the source register to learn which fired
	irt_route u_route (
		.src_event_i(src_event_i),
		.enable_i(enable_r),
		.routing_i(route_view),
		.pin_first_o(route_first),
		.pin_second_o(route_second)
	);

	// pressure: 4 Pa per trim lsb on a quarter-pascal grid
	irt_trim #(
		.SHIFT(irt_pkg::P_TRIM_SHIFT) // R7
	) u_trim_p (
		.result_i(p_result_i),
		.trim_i(p_trim_r),
		.result_o(p_trimmed)
	);

	// temperature: trim lsb equals result lsb, 1/16 degC
	irt_trim #(
		.SHIFT(irt_pkg::T_TRIM_SHIFT) // R8
	) u_trim_t (
		.result_i(t_result_i),
		.trim_i(t_trim_r),
		.result_o(t_trimmed)
	);

	// altitude: whole meters on a 1/16 m grid
	irt_trim #(
		.SHIFT(irt_pkg::H_TRIM_SHIFT) // R9
	) u_trim_h (
		.result_i(h_result_i),
		.trim_i(h_trim_r),
		.result_o(h_trimmed)
	);

	// next pin and result values; results only move on a new measurement so a
	// trim written mid-stream takes effect at the next conversion
	always_comb begin
		pin_first_nxt = route_first; // R4
		pin_second_nxt = route_second; // R4
		p_out_nxt = p_out_r;
		t_out_nxt = t_out_r;
		h_out_nxt = h_out_r;
		valid_nxt = 1'b0;
		if (result_valid_i) begin
			p_out_nxt = p_trimmed; // R12
			t_out_nxt = t_trimmed; // R12
			h_out_nxt = h_trimmed; // R12
			valid_nxt = 1'b1;
		end
	end

	// pin and result flops; one cycle latency from event to pin
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pin_first_r <= 1'b0;
			pin_second_r <= 1'b0;
			p_out_r <= 24'sh000000;
			t_out_r <= 24'sh000000;
			h_out_r <= 24'sh000000;
			valid_r <= 1'b0;
		end else begin
			pin_first_r <= pin_first_nxt;
			pin_second_r <= pin_second_nxt;
			p_out_r <= p_out_nxt;
			t_out_r <= t_out_nxt;
			h_out_r <= h_out_nxt;
			valid_r <= valid_nxt;
		end
	end

	// outputs straight from flops; pin polarity and drive live in another bank
	always_comb begin
		reg_rdata_o = rdata_r;
		irq_pin_first_o = pin_first_r;
		irq_pin_second_o = pin_second_r;
		p_out_o = p_out_r;
		t_out_o = t_out_r;
		h_out_o = h_out_r;
		out_valid_o = valid_r;
	end
endmodule // irt_bank
`default_nettype wire

// ### sim/irt_host_model.sv
// irt_host_model: host controller stand-in driving the register strobe port
`timescale 1ns/100ps
`default_nettype none
module irt_host_model (
	input wire logic clk_i, // core clock
	output logic wr_o, // write strobe
	output logic rd_o, // read strobe
	output logic [7:0] addr_o, // register address
	output logic [7:0] wdata_o // write data
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// one strobe per call; the caller, not the pin, works out the cause of an interrupt
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= w;
		rd_o <= !w;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		addr_o <= ~a; // released address inverted as well, so no stale decode
		wdata_o <= ~d; // released data inverted so stale bytes never look valid
	endtask
endmodule // irt_host_model
`default_nettype wire

// ### sim/irt_bank_sva.sv
// irt_bank_sva: port-level checker for the routing and trim bank
`timescale 1ns/100ps
`default_nettype none
module irt_bank_sva (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [7:0] src_event_i,
	input wire logic signed [23:0] p_result_i,
	input wire logic signed [23:0] t_result_i,
	input wire logic signed [23:0] h_result_i,
	input wire logic result_valid_i,
	input wire logic irq_pin_first_o,
	input wire logic irq_pin_second_o,
	input wire logic signed [23:0] p_out_o,
	input wire logic signed [23:0] t_out_o,
	input wire logic signed [23:0] h_out_o,
	input wire logic out_valid_o
);
	logic [7:0] sh_r [5]; // shadow of enable, routing and the three trims
	logic [7:0] rd_want; // expected read byte
	function automatic logic [23:0] sx(input logic [7:0] v);
		return {{16{v[7]}}, v};
	endfunction
	// shadow follows host writes so expectations never peek at design state
	always_ff @(posedge core_clk_i) begin
		for (int k = 0; k < 5; k++) begin
			if (rst_i) begin
				sh_r[k] <= 8'h00;
			end else if (reg_wr_i && reg_addr_i == 8'h29 + 8'(k)) begin
				sh_r[k] <= reg_wdata_i;
			end
		end
	end
	// unmapped places read as zero
	always_comb rd_want = (reg_addr_i >= 8'h29 && reg_addr_i <= 8'h2d) ? sh_r[3'(reg_addr_i - 8'h29)] : 8'h00;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	AST_PIN_FIRST: assert property (irq_pin_first_o == $past(|(src_event_i & sh_r[0] & sh_r[1])))
		else $error("first pin wrong");
	AST_PIN_SECOND: assert property (irq_pin_second_o == $past(|(src_event_i & sh_r[0] & ~sh_r[1])))
		else $error("second pin wrong");
	AST_READ: assert property (reg_rd_i |=> reg_rdata_o == $past(rd_want))
		else $error("read data wrong");
	AST_READ_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
	AST_VALID: assert property (out_valid_o == $past(result_valid_i)) else $error("out valid wrong");
	AST_P: assert property (result_valid_i |=> p_out_o == $past(p_result_i + (sx(sh_r[2]) << 4)))
		else $error("pressure trim wrong");
	AST_T: assert property (result_valid_i |=> t_out_o == $past(t_result_i + sx(sh_r[3])))
		else $error("temperature trim wrong");
	AST_H: assert property (result_valid_i |=> h_out_o == $past(h_result_i + (sx(sh_r[4]) << 4)))
		else $error("altitude trim wrong");
endmodule // irt_bank_sva
bind irt_bank irt_bank_sva irt_bank_sva_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.src_event_i(src_event_i), .p_result_i(p_result_i), .t_result_i(t_result_i), .h_result_i(h_result_i),
	.result_valid_i(result_valid_i), .irq_pin_first_o(irq_pin_first_o), .irq_pin_second_o(irq_pin_second_o),
	.p_out_o(p_out_o), .t_out_o(t_out_o), .h_out_o(h_out_o), .out_valid_o(out_valid_o));
`default_nettype wire

// ### sim/irt_bank_bench.sv
// irt_bank_bench: self-checking bench for the routing and trim bank
`timescale 1ns/100ps
`default_nettype none
module irt_bank_bench;
	logic core_clk = 1'b0, rst = 1'b1, rv = 1'b0, rd_seen = 1'b0, wr, rd, f1, f2, ov;
	logic [7:0] addr, wdata, rdata, rt, en, src = 8'h00;
	logic [7:0] tr [3];
	logic [7:0] tv [3] = '{8'h80, 8'h7f, 8'h00}; // trim boundaries and zero
	logic signed [23:0] p = 24'h0, t = 24'h0, h = 24'h0, po, to, ho;
	logic [23:0] exp_q [$]; // expected reads and results in order
	int failures = 0, comparisons = 0;
	always #25 core_clk = ~core_clk; // 20 MHz
	irt_host_model irt_host_model_inst (.clk_i(core_clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
	irt_bank irt_bank_inst (.core_clk_i(core_clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .src_event_i(src), .p_result_i(p), .t_result_i(t), .h_result_i(h),
		.result_valid_i(rv), .irq_pin_first_o(f1), .irq_pin_second_o(f2), .p_out_o(po), .t_out_o(to), .h_out_o(ho),
		.out_valid_o(ov));
	task automatic check(input logic [23:0] seen, input logic [23:0] want);
		comparisons++;
		if (seen !== want) begin
			failures++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic print_verdict;
		if (failures == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	function automatic logic [23:0] sx(input logic [7:0] v);
		return {{16{v[7]}}, v};
	endfunction
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({16'h0, e});
		irt_host_model_inst.xfer(1'b0, a, 8'h00);
	endtask
	// drive one event pattern, then look at both pins once the one-cycle lag has passed
	task automatic pins(input logic [7:0] s, input logic e1, input logic e2);
		@(posedge core_clk);
		src <= s;
		@(posedge core_clk);
		@(negedge core_clk);
		check(f1, e1);
		check(f2, e2);
	endtask
	always @(posedge core_clk) rd_seen <= rd;
	// watcher: pops the oldest note when read data or a result appears
	always @(negedge core_clk) begin
		if (rd_seen) check(rdata, exp_q.pop_front());
		if (ov === 1'b1) begin
			check(po, exp_q.pop_front());
			check(to, exp_q.pop_front());
			check(ho, exp_q.pop_front());
		end
	end
	initial begin
		void'($urandom(71284));
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		for (int a = 8'h29; a <= 8'h2e; a++) rd_exp(8'(a), 8'h00);
		rt = 8'($urandom);
		irt_host_model_inst.xfer(1'b1, 8'h29, 8'hff);
		rd_exp(8'h29, 8'hff);
		irt_host_model_inst.xfer(1'b1, 8'h2a, rt);
		rd_exp(8'h2a, rt);
		// a write to an unmapped place must not land anywhere
		irt_host_model_inst.xfer(1'b1, 8'h2e, 8'h5a);
		rd_exp(8'h2e, 8'h00);
		for (int i = 0; i < 8; i++) pins(8'h01 << i, rt[i], !rt[i]);
		pins(8'hff, |rt, ~&rt);
		// mixed enables: only enabled sources may reach either pin
		en = 8'($urandom);
		irt_host_model_inst.xfer(1'b1, 8'h29, en);
		pins(8'hff, |(rt & en), |(~rt & en));
		irt_host_model_inst.xfer(1'b1, 8'h29, 8'h00);
		pins(8'hff, 1'b0, 1'b0);
		// each pass sets all trims, then sends two back-to-back results
		for (int j = 0; j < 4; j++) begin
			for (int k = 0; k < 3; k++) begin
				tr[k] = (j < 3) ? tv[(j + k) % 3] : 8'($urandom);
				irt_host_model_inst.xfer(1'b1, 8'h2b + 8'(k), tr[k]);
				rd_exp(8'h2b + 8'(k), tr[k]);
			end
			repeat (2) begin
				@(posedge core_clk);
				rv <= 1'b1;
				p <= 24'($urandom);
				t <= 24'($urandom);
				h <= 24'($urandom);
				#1;
				exp_q.push_back(p + (sx(tr[0]) << 4));
				exp_q.push_back(t + sx(tr[1]));
				exp_q.push_back(h + (sx(tr[2]) << 4));
			end
			@(posedge core_clk);
			rv <= 1'b0;
		end
		// mid-run reset: every register must read zero again and the pins fall quiet
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		for (int a = 8'h29; a <= 8'h2d; a++) rd_exp(8'(a), 8'h00);
		pins(8'hff, 1'b0, 1'b0);
		for (int n = 0; n < 20 && exp_q.size() > 0; n++) @(posedge core_clk);
		if (exp_q.size() > 0) failures++;
		print_verdict();
	end
endmodule // irt_bank_bench
`default_nettype wire
